// ---- src/adc_sfr_pkg.sv ----
// adc_sfr_pkg: addresses, reset values, field positions and carriers
// for the converter status/mode SFR bank; assumes an 8-bit SFR space
package adc_sfr_pkg;
   // byte addresses in the special-function space
   localparam logic [7:0] STAT_ADDR = 8'hD8;
   localparam logic [7:0] MODE_ADDR = 8'hD1;
   localparam logic [7:0] DECIM_ADDR = 8'hD4;
   localparam logic [7:0] RES0_ADDR = 8'hD9; // low, mid, high
   localparam logic [7:0] RES1_ADDR = 8'hDC; // low, high
   localparam logic [7:0] OFS0_ADDR = 8'hE1;
   localparam logic [7:0] OFS1_ADDR = 8'hE4;
   localparam logic [7:0] GAIN0_ADDR = 8'hE9;
   localparam logic [7:0] GAIN1_ADDR = 8'hEC;
   localparam logic [7:0] SPAN3 = 8'h03;
   localparam logic [7:0] SPAN2 = 8'h02;
   // reset values
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h08;
   localparam logic [7:0] DECIM_RESET = 8'h45;
   localparam logic [23:0] OFS_RESET = 24'h800000;
   localparam logic [23:0] GAIN_RESET = 24'h400000;
   localparam logic [23:0] RES_RESET = 24'h000000;
   localparam logic [23:0] ALL_ONES = 24'hFFFFFF;
   // status bit positions
   localparam int PRI_READY_BIT = 7;
   localparam int AUX_READY_BIT = 6;
   localparam int CAL_BIT = 5;
   localparam int NOREF_BIT = 4;
   localparam int PRI_ERR_BIT = 3;
   localparam int AUX_ERR_BIT = 2;
   // mode register fields
   localparam int PRI_EN_BIT = 5;
   localparam int AUX_EN_BIT = 4;
   localparam int MD_CAL_BIT = 2; // set for every calibration code
   localparam int MD_GAIN_BIT = 0; // full-scale versus zero-scale
   localparam logic [7:0] MODE_WR_MASK = 8'h7F; // bit 7 unimplemented
   localparam logic [2:0] MD_FIRST_RUN = 3'h2; // lowest code that starts work
   localparam logic [2:0] MD_SYS_ZERO_CAL = 3'h6;
   localparam logic [2:0] MD_SYS_FULL_CAL = 3'h7;
   // 16-bit variant would clear this to hide the low byte of each three-byte register
   localparam logic LOW_BYTE_PRESENT = 1'b1;

   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_CONV = 2'b01,
      OP_CAL = 2'b11
   } op_state_t;

   // one completion report from a converter engine
   typedef struct packed {
      logic done;
      logic clamped;
      logic calFail;
      logic [23:0] data;
   } conv_event_t;
endpackage : adc_sfr_pkg

// ---- src/adc_status_and_control_regs.sv ----
// adc_status_and_control_regs: converter status, mode, decimation, result
// and coefficient SFRs; sits on the core SFR byte bus and bit bus, and
// takes one-cycle completion reports from the two converter engines
`timescale 1ns/100ps

// Overview of operation
// RULE1: primary done or cal sets primary ready
// RULE2: ready clears by write or cal start
// RULE3: ready set blocks primary result/coefficient writes
// RULE4: auxiliary ready behaves like primary ready
// RULE5: finished calibration sets calibration flag
// RULE6: starting conversion or calibration clears it
// RULE7: calibration with temperature sensor never completes
// RULE8: missing reference tracked while converter active
// RULE9: missing reference forces results all ones
// RULE10: clamped primary result sets primary error
// RULE11: failed calibration also sets primary error
// RULE12: starting conversion or calibration clears error
// RULE13: auxiliary error behaves like primary error
// RULE14: status bits 1,0 unimplemented, writes ignored
// RULE15: status at D8H, resets 00H, bit addressable
// RULE16: mode at D1H, resets 08H, byte only
// RULE17: primary result as three bytes
// RULE18: primary offset coefficient as three bytes
// RULE19: auxiliary offset coefficient as two bytes
// RULE20: primary gain coefficient as three bytes
// RULE21: auxiliary gain coefficient as two bytes
// RULE22: decimation register sets sinc filter rate
// RULE23: mode 110 zero-scale, 111 full-scale calibration
// RULE24: primary enable runs, clear powers down
module adc_status_and_control_regs (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrEn,
   input wire logic [7:0] sfrWrData,
   output logic [7:0] sfrRdData,
   input wire logic [7:0] bitAddr,
   input wire logic bitWrEn,
   input wire logic bitWrData,
   output logic bitRdData,
   input wire adc_sfr_pkg::conv_event_t priEvent,
   input wire adc_sfr_pkg::conv_event_t auxEvent,
   input wire logic refBad,
   input wire logic auxTempSel,
   output logic [7:0] modeCtrl,
   output logic priRun,
   output logic auxRun,
   output logic opStart,
   output logic [7:0] decimation,
   output logic [23:0] priOffset,
   output logic [23:0] priGain,
   output logic [15:0] auxOffset,
   output logic [15:0] auxGain
);

   // true when a lies inside [base, base+span)
   function automatic logic inWin(input logic [7:0] a, input logic [7:0] base,
                                  input logic [7:0] span);
      logic [7:0] d;
      d = 8'(a - base);
      inWin = d < span;
   endfunction : inWin

   // byte index of a inside its window
   function automatic logic [1:0] idxOf(input logic [7:0] a, input logic [7:0] base);
      idxOf = 2'(a - base);
   endfunction : idxOf

   // byte i of a 24-bit value; the low byte vanishes on the narrow variant
   function automatic logic [7:0] pickByte(input logic [23:0] v, input logic [1:0] i);
      case (i)
         2'h0: pickByte = adc_sfr_pkg::LOW_BYTE_PRESENT ? v[7:0] : 8'h00;
         2'h1: pickByte = v[15:8];
         default: pickByte = v[23:16];
      endcase
   endfunction : pickByte

   // replace byte i of a 24-bit value
   function automatic logic [23:0] putByte(input logic [23:0] v, input logic [1:0] i,
                                           input logic [7:0] b);
      logic [23:0] r;
      r = v;
      case (i)
         2'h0: r[7:0] = b;
         2'h1: r[15:8] = b;
         default: r[23:16] = b;
      endcase
      putByte = r;
   endfunction : putByte

   logic [7:0] status;
   logic [7:0] next_status;
   logic [7:0] next_modeCtrl;
   logic [7:0] next_decimation;
   adc_sfr_pkg::op_state_t opState;
   adc_sfr_pkg::op_state_t next_opState;
   logic tempCalBlock;
   logic next_tempCalBlock;
   logic next_opStart;
   logic [23:0] priResult;
   logic [23:0] next_priResult;
   logic [15:0] auxResult;
   logic [15:0] next_auxResult;
   logic [23:0] next_priOffset;
   logic [23:0] next_priGain;
   logic [15:0] next_auxOffset;
   logic [15:0] next_auxGain;
   logic [7:0] next_sfrRdData;
   logic next_bitRdData;

   // decoded strobes shared by the groups below
   logic modeWr;
   logic startOp;
   logic calStart;
   logic priTake;
   logic auxTake;
   logic inCal;
   logic [2:0] newMd;

   assign newMd = sfrWrData[2:0];
   assign modeWr = sfrWrEn && (sfrAddr == adc_sfr_pkg::MODE_ADDR); // RULE16
   assign startOp = modeWr && (newMd >= adc_sfr_pkg::MD_FIRST_RUN);
   assign calStart = startOp && newMd[adc_sfr_pkg::MD_CAL_BIT]; // RULE23
   assign inCal = (opState == adc_sfr_pkg::OP_CAL);
   // a report is dropped while its ready flag still stands
   assign priTake = priEvent.done && !status[adc_sfr_pkg::PRI_READY_BIT]; // RULE3
   // a temperature-sensor calibration on the auxiliary side never lands
   assign auxTake = auxEvent.done && !status[adc_sfr_pkg::AUX_READY_BIT]
                    && !(inCal && tempCalBlock); // RULE4 RULE7
   assign priRun = modeCtrl[adc_sfr_pkg::PRI_EN_BIT]; // RULE24
   assign auxRun = modeCtrl[adc_sfr_pkg::AUX_EN_BIT];

   // status flags, mode, decimation and operation tracking
   always_comb begin
      next_status = status;
      next_modeCtrl = modeCtrl;
      next_decimation = decimation;
      next_opState = opState;
      next_tempCalBlock = tempCalBlock;
      next_opStart = startOp;
      // software writes first, so hardware sets below win a same-cycle clash
      if (sfrWrEn && sfrAddr == adc_sfr_pkg::STAT_ADDR) begin // RULE15
         next_status[7:5] = sfrWrData[7:5]; // RULE2
         next_status[3:2] = sfrWrData[3:2];
      end
      if (bitWrEn && bitAddr[7:3] == adc_sfr_pkg::STAT_ADDR[7:3]
          && bitAddr[2:0] != 3'(adc_sfr_pkg::NOREF_BIT)
          && bitAddr[2:1] != 2'h0) begin // RULE14 RULE15
         next_status[bitAddr[2:0]] = bitWrData;
      end
      if (modeWr) begin
         next_modeCtrl = sfrWrData & adc_sfr_pkg::MODE_WR_MASK;
         next_opState = adc_sfr_pkg::OP_IDLE;
      end
      if (sfrWrEn && sfrAddr == adc_sfr_pkg::DECIM_ADDR) begin
         next_decimation = sfrWrData; // RULE22
      end
      if (startOp) begin
         next_status[adc_sfr_pkg::CAL_BIT] = 1'b0; // RULE6
         next_status[adc_sfr_pkg::PRI_ERR_BIT] = 1'b0; // RULE12
         next_status[adc_sfr_pkg::AUX_ERR_BIT] = 1'b0; // RULE13
         next_opState = calStart ? adc_sfr_pkg::OP_CAL : adc_sfr_pkg::OP_CONV;
         next_tempCalBlock = calStart && auxTempSel; // RULE7
      end
      if (calStart) begin
         next_status[adc_sfr_pkg::PRI_READY_BIT] = 1'b0; // RULE2
         next_status[adc_sfr_pkg::AUX_READY_BIT] = 1'b0; // RULE4
      end
      // hardware sets
      if (priTake) begin
         next_status[adc_sfr_pkg::PRI_READY_BIT] = 1'b1; // RULE1
         if (inCal) begin
            next_status[adc_sfr_pkg::CAL_BIT] = 1'b1; // RULE5
            if (priEvent.calFail) begin
               next_status[adc_sfr_pkg::PRI_ERR_BIT] = 1'b1; // RULE11
            end
         end else if (priEvent.clamped || status[adc_sfr_pkg::NOREF_BIT]) begin
            next_status[adc_sfr_pkg::PRI_ERR_BIT] = 1'b1; // RULE10
         end
      end
      if (auxTake) begin
         next_status[adc_sfr_pkg::AUX_READY_BIT] = 1'b1; // RULE4
         if (inCal) begin
            next_status[adc_sfr_pkg::CAL_BIT] = 1'b1; // RULE5
            if (auxEvent.calFail) begin
               next_status[adc_sfr_pkg::AUX_ERR_BIT] = 1'b1; // RULE13
            end
         end else if (auxEvent.clamped || status[adc_sfr_pkg::NOREF_BIT]) begin
            next_status[adc_sfr_pkg::AUX_ERR_BIT] = 1'b1; // RULE13
         end
      end
      // calibration is one-shot: a finished one leaves the engines idle
      if (inCal && !startOp && (priTake || auxTake)) begin
         next_opState = adc_sfr_pkg::OP_IDLE;
      end
      // only the main reference is watched, the second pair is not
      next_status[adc_sfr_pkg::NOREF_BIT] = refBad
         && (next_modeCtrl[adc_sfr_pkg::PRI_EN_BIT]
             || next_modeCtrl[adc_sfr_pkg::AUX_EN_BIT]); // RULE8
      next_status[1:0] = 2'h0; // RULE14
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= adc_sfr_pkg::STAT_RESET; // RULE15
         modeCtrl <= adc_sfr_pkg::MODE_RESET; // RULE16
         decimation <= adc_sfr_pkg::DECIM_RESET;
         opState <= adc_sfr_pkg::OP_IDLE;
         tempCalBlock <= 1'b0;
         opStart <= 1'b0;
      end else if (clkEn) begin
         status <= next_status;
         modeCtrl <= next_modeCtrl;
         decimation <= next_decimation;
         opState <= next_opState;
         tempCalBlock <= next_tempCalBlock;
         opStart <= next_opStart;
      end
   end

   // result and coefficient storage; engine updates beat software writes
   always_comb begin
      next_priResult = priResult;
      next_auxResult = auxResult;
      next_priOffset = priOffset;
      next_priGain = priGain;
      next_auxOffset = auxOffset;
      next_auxGain = auxGain;
      if (sfrWrEn && inWin(sfrAddr, adc_sfr_pkg::OFS0_ADDR, adc_sfr_pkg::SPAN3)) begin
         next_priOffset = putByte(priOffset, idxOf(sfrAddr, adc_sfr_pkg::OFS0_ADDR),
                                  sfrWrData);
      end
      if (sfrWrEn && inWin(sfrAddr, adc_sfr_pkg::GAIN0_ADDR, adc_sfr_pkg::SPAN3)) begin
         next_priGain = putByte(priGain, idxOf(sfrAddr, adc_sfr_pkg::GAIN0_ADDR),
                                sfrWrData);
      end
      if (sfrWrEn && inWin(sfrAddr, adc_sfr_pkg::OFS1_ADDR, adc_sfr_pkg::SPAN2)) begin
         next_auxOffset = 16'(putByte({8'h00, auxOffset},
                                      idxOf(sfrAddr, adc_sfr_pkg::OFS1_ADDR), sfrWrData));
      end
      if (sfrWrEn && inWin(sfrAddr, adc_sfr_pkg::GAIN1_ADDR, adc_sfr_pkg::SPAN2)) begin
         next_auxGain = 16'(putByte({8'h00, auxGain},
                                    idxOf(sfrAddr, adc_sfr_pkg::GAIN1_ADDR), sfrWrData));
      end
      if (priTake && inCal && !priEvent.calFail) begin // RULE11
         if (modeCtrl[adc_sfr_pkg::MD_GAIN_BIT]) begin
            next_priGain = priEvent.data; // RULE20
         end else begin
            next_priOffset = priEvent.data; // RULE18
         end
      end else if (priTake && !inCal) begin
         next_priResult = status[adc_sfr_pkg::NOREF_BIT] ? adc_sfr_pkg::ALL_ONES
                          : priEvent.data; // RULE9 RULE17
      end
      if (auxTake && inCal && !auxEvent.calFail) begin
         if (modeCtrl[adc_sfr_pkg::MD_GAIN_BIT]) begin
            next_auxGain = auxEvent.data[23:8]; // RULE21
         end else begin
            next_auxOffset = auxEvent.data[23:8]; // RULE19
         end
      end else if (auxTake && !inCal) begin
         next_auxResult = status[adc_sfr_pkg::NOREF_BIT] ? adc_sfr_pkg::ALL_ONES[15:0]
                          : auxEvent.data[23:8]; // RULE9
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         priResult <= adc_sfr_pkg::RES_RESET;
         auxResult <= adc_sfr_pkg::RES_RESET[15:0];
         priOffset <= adc_sfr_pkg::OFS_RESET;
         priGain <= adc_sfr_pkg::GAIN_RESET;
         auxOffset <= adc_sfr_pkg::OFS_RESET[23:8];
         auxGain <= adc_sfr_pkg::GAIN_RESET[23:8];
      end else if (clkEn) begin
         priResult <= next_priResult;
         auxResult <= next_auxResult;
         priOffset <= next_priOffset;
         priGain <= next_priGain;
         auxOffset <= next_auxOffset;
         auxGain <= next_auxGain;
      end
   end

   // read-back, registered; unmapped addresses read zero
   always_comb begin
      next_sfrRdData = 8'h00;
      if (sfrAddr == adc_sfr_pkg::STAT_ADDR) begin
         next_sfrRdData = status;
      end else if (sfrAddr == adc_sfr_pkg::MODE_ADDR) begin
         next_sfrRdData = modeCtrl;
      end else if (sfrAddr == adc_sfr_pkg::DECIM_ADDR) begin
         next_sfrRdData = decimation;
      end else if (inWin(sfrAddr, adc_sfr_pkg::RES0_ADDR, adc_sfr_pkg::SPAN3)) begin
         next_sfrRdData = pickByte(priResult, idxOf(sfrAddr, adc_sfr_pkg::RES0_ADDR));
      end else if (inWin(sfrAddr, adc_sfr_pkg::RES1_ADDR, adc_sfr_pkg::SPAN2)) begin
         next_sfrRdData = idxOf(sfrAddr, adc_sfr_pkg::RES1_ADDR) == 2'h0 ?
                          auxResult[7:0] : auxResult[15:8];
      end else if (inWin(sfrAddr, adc_sfr_pkg::OFS0_ADDR, adc_sfr_pkg::SPAN3)) begin
         next_sfrRdData = pickByte(priOffset, idxOf(sfrAddr, adc_sfr_pkg::OFS0_ADDR));
      end else if (inWin(sfrAddr, adc_sfr_pkg::GAIN0_ADDR, adc_sfr_pkg::SPAN3)) begin
         next_sfrRdData = pickByte(priGain, idxOf(sfrAddr, adc_sfr_pkg::GAIN0_ADDR));
      end else if (inWin(sfrAddr, adc_sfr_pkg::OFS1_ADDR, adc_sfr_pkg::SPAN2)) begin
         next_sfrRdData = idxOf(sfrAddr, adc_sfr_pkg::OFS1_ADDR) == 2'h0 ?
                          auxOffset[7:0] : auxOffset[15:8];
      end else if (inWin(sfrAddr, adc_sfr_pkg::GAIN1_ADDR, adc_sfr_pkg::SPAN2)) begin
         next_sfrRdData = idxOf(sfrAddr, adc_sfr_pkg::GAIN1_ADDR) == 2'h0 ?
                          auxGain[7:0] : auxGain[15:8];
      end
      next_bitRdData = (bitAddr[7:3] == adc_sfr_pkg::STAT_ADDR[7:3]) ?
                       status[bitAddr[2:0]] : 1'b0;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfrRdData <= 8'h00;
         bitRdData <= 1'b0;
      end else if (clkEn) begin
         sfrRdData <= next_sfrRdData;
         bitRdData <= next_bitRdData;
      end
   end

endmodule : adc_status_and_control_regs

// ---- verif/adc_regs_monitor.sv ----
// adc_regs_monitor: port-level checks on the converter status/mode bank;
// assumes one core_clk domain and clkEn held high in normal use
`timescale 1ns/100ps
module adc_regs_monitor (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic sfrWrEn,
   input wire logic bitWrEn,
   input wire logic bitWrData,
   input wire logic bitRdData,
   input wire logic opStart,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic [7:0] sfrRdData,
   input wire logic [7:0] bitAddr,
   input wire logic [7:0] modeCtrl,
   input wire adc_sfr_pkg::conv_event_t priEvent,
   input wire adc_sfr_pkg::conv_event_t auxEvent,
   input wire logic [23:0] priOffset,
   input wire logic [23:0] priGain
);
   // write decodes; quiet means no byte write, no bit write and no primary report in that cycle
   wire logic modeWr = clkEn && sfrWrEn && sfrAddr == 8'hD1;
   wire logic startWr = modeWr && sfrWrData[2:0] >= adc_sfr_pkg::MD_FIRST_RUN;
   wire logic calWr = modeWr && sfrWrData[adc_sfr_pkg::MD_CAL_BIT];
   wire logic quiet = !sfrWrEn && !bitWrEn && !priEvent.done;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   // status reaches the read ports two edges after its cause
   sequence priDoneLook;
      priEvent.done && !sfrWrEn && !bitWrEn ##1 !sfrWrEn && !bitWrEn ##1 bitAddr == 8'hDF;
   endsequence
   sequence clearLook;
      bitWrEn && bitAddr == 8'hDF && !bitWrData && !priEvent.done ##1 quiet
         ##1 bitAddr == 8'hDF;
   endsequence
   sequence calLook;
      calWr && !bitWrEn && !priEvent.done ##1 quiet ##1 bitAddr == 8'hDF;
   endsequence
   sequence startLook;
      startWr && !bitWrEn && !priEvent.done && !auxEvent.done ##1 quiet && !auxEvent.done
         ##1 sfrAddr == 8'hD8;
   endsequence
   AST_MODE_WRITE: assert property (modeWr |=> modeCtrl == ($past(sfrWrData) & 8'h7F))
      else $error("mode register did not take the written value");
   AST_OPSTART_PULSE: assert property (opStart == $past(startWr))
      else $error("start pulse does not follow a starting mode write");
   AST_STAT_LOW_BITS: assert property (
      clkEn && sfrAddr == 8'hD8 |=> sfrRdData[1:0] == 2'h0)
      else $error("unimplemented status bits read back nonzero");
   AST_BIT_LOW_BITS: assert property (
      clkEn && bitAddr inside {8'hD8, 8'hD9} |=> !bitRdData)
      else $error("unimplemented status bit read back as one");
   AST_PRI_READY_SET: assert property (priDoneLook |=> bitRdData)
      else $error("primary ready missing after a report");
   AST_PRI_READY_BIT_CLEAR: assert property (clearLook |=> !bitRdData)
      else $error("primary ready survived a bit clear");
   AST_PRI_READY_CAL_CLEAR: assert property (calLook |=> !bitRdData)
      else $error("primary ready survived a calibration start");
   AST_START_CLEARS: assert property (
      startLook |=> !sfrRdData[5] && sfrRdData[3:2] == 2'h0)
      else $error("start left calibration or error flags set");
   AST_COEF_HOLD: assert property (
      !sfrWrEn && !priEvent.done |=> $stable(priOffset) && $stable(priGain))
      else $error("primary coefficient moved without a cause");
endmodule : adc_regs_monitor

bind adc_status_and_control_regs adc_regs_monitor mon (
   .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .sfrWrEn(sfrWrEn),
   .bitWrEn(bitWrEn), .bitWrData(bitWrData), .bitRdData(bitRdData), .opStart(opStart),
   .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
   .modeCtrl(modeCtrl), .priEvent(priEvent), .auxEvent(auxEvent),
   .priOffset(priOffset), .priGain(priGain)
);

// ---- verif/conv_engine_model.sv ----
// conv_engine_model: behavioural converter engine, one report per go
// pulse lag+1 cycles later; shares core_clk and reset_n with the bank
`timescale 1ns/100ps
module conv_engine_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic go,
   input wire logic [3:0] lag,
   input wire logic [25:0] fields,
   output adc_sfr_pkg::conv_event_t ev
);
   logic [4:0] count;
   // count[4] marks a pending report; fields keep moving between reports
   // so a bank that samples them without done is caught out
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= 5'h00;
         ev <= '0;
      end else if (go) begin
         count <= {1'b1, lag};
         ev <= {1'b0, ~ev[25:0]};
      end else if (count == 5'h10) begin
         count <= 5'h00;
         ev <= {1'b1, fields};
      end else begin
         count <= count[4] ? count - 5'h01 : count;
         ev <= {1'b0, ~ev[25:0]};
      end
   end
endmodule : conv_engine_model

// ---- verif/tb_top.sv ----
// tb_top: self-checking bench for the converter status/mode bank;
// assumes the bank, two engine models and a 250 MHz core clock
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] exp;
   } row_t;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic clkEn = 1'b1; // dropped once to show a frozen write is lost
   logic sfrWrEn = 1'b0, bitWrEn = 1'b0, bitWrData = 1'b0, refBad = 1'b0, auxTempSel = 1'b0;
   logic goP = 1'b0, goA = 1'b0;
   logic [7:0] sfrAddr = 8'h00, sfrWrData = 8'h00, bitAddr = 8'h00;
   logic [3:0] lag = 4'h0;
   logic [25:0] evF = 26'h0;
   logic [7:0] sfrRdData, modeCtrl, decimation;
   logic bitRdData, priRun, auxRun, opStart;
   logic [23:0] priOffset, priGain;
   logic [15:0] auxOffset, auxGain;
   adc_sfr_pkg::conv_event_t priEvent, auxEvent;
   int errors = 0;
   int checks_done = 0;
   // plain register accesses: write flag, address, data, expected read
   row_t rows [16] = '{
      {1'b0, 8'hD8, 8'h00, 8'h00}, {1'b0, 8'hD1, 8'h00, 8'h08},
      {1'b0, 8'hD4, 8'h00, 8'h45}, {1'b0, 8'hE3, 8'h00, 8'h80},
      {1'b0, 8'hE1, 8'h00, 8'h00}, {1'b0, 8'hEB, 8'h00, 8'h40},
      {1'b0, 8'hE5, 8'h00, 8'h80}, {1'b0, 8'hED, 8'h00, 8'h40},
      {1'b0, 8'hDB, 8'h00, 8'h00}, {1'b1, 8'hD1, 8'h88, 8'h08},
      {1'b1, 8'hD8, 8'h03, 8'h00}, {1'b1, 8'hD4, 8'h12, 8'h12},
      {1'b1, 8'hE2, 8'h5A, 8'h5A}, {1'b1, 8'hEC, 8'hA5, 8'hA5},
      {1'b1, 8'hD9, 8'h33, 8'h00}, {1'b0, 8'h80, 8'h00, 8'h00}
   };
   adc_status_and_control_regs dut (
      .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .sfrAddr(sfrAddr),
      .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .bitAddr(bitAddr),
      .bitWrEn(bitWrEn), .bitWrData(bitWrData), .bitRdData(bitRdData), .priEvent(priEvent),
      .auxEvent(auxEvent), .refBad(refBad), .auxTempSel(auxTempSel), .modeCtrl(modeCtrl),
      .priRun(priRun), .auxRun(auxRun), .opStart(opStart), .decimation(decimation),
      .priOffset(priOffset), .priGain(priGain), .auxOffset(auxOffset), .auxGain(auxGain)
   );
   conv_engine_model priModel (.core_clk(core_clk), .reset_n(reset_n), .go(goP), .lag(lag),
      .fields(evF), .ev(priEvent));
   conv_engine_model auxModel (.core_clk(core_clk), .reset_n(reset_n), .go(goA), .lag(lag),
      .fields(evF), .ev(auxEvent));
   // 4 ns period
   always #2 core_clk = ~core_clk;
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   // each access drives 1 ns after an edge and holds across the next one
   task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) #1;
      {sfrAddr, sfrWrData, sfrWrEn} = {a, d, 1'b1};
      @(posedge core_clk) #1;
      sfrWrEn = 1'b0;
   endtask : wr_sfr
   task automatic rd_sfr(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk) #1;
      sfrAddr = a;
      @(posedge core_clk) #1;
      check(24'(sfrRdData), 24'(e));
   endtask : rd_sfr
   task automatic wr_bit(input logic [7:0] a, input logic d);
      @(posedge core_clk) #1;
      {bitAddr, bitWrData, bitWrEn} = {a, d, 1'b1};
      @(posedge core_clk) #1;
      bitWrEn = 1'b0;
   endtask : wr_bit
   task automatic rd_bit(input logic [7:0] a, input logic e);
      @(posedge core_clk) #1;
      bitAddr = a;
      @(posedge core_clk) #1;
      check(24'(bitRdData), 24'(e));
   endtask : rd_bit
   // f is {clamped, calFail, data}; returns at the edge the bank takes it
   task automatic fire(input logic aux, input logic [3:0] l, input logic [25:0] f);
      logic seen;
      seen = 1'b0;
      @(posedge core_clk) #1;
      {goA, goP, lag, evF} = {aux, !aux, l, f};
      @(posedge core_clk) #1;
      {goA, goP} = 2'b00;
      for (int i = 0; i < 40 && seen !== 1'b1; i++) begin
         @(posedge core_clk);
         seen = aux ? auxEvent.done : priEvent.done;
      end
      if (seen !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask : fire
   task automatic end_of_test();
      $display("checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5) @(posedge core_clk);
      check(24'(modeCtrl), 24'h08);
      #1 reset_n = 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr_sfr(rows[i].addr, rows[i].data);
         rd_sfr(rows[i].addr, rows[i].exp);
      end
      check(priOffset, 24'h805A00);
      check(24'(auxGain), 24'h40A5);
      check(24'(decimation), 24'h12);
      // conversion report fills the result bytes and raises ready
      wr_sfr(8'hD1, 8'h22);
      check(24'(opStart), 24'h1);
      check(24'(priRun), 24'h1);
      fire(1'b0, 4'h0, {2'b00, 24'h123456});
      rd_bit(8'hDF, 1'b1);
      rd_sfr(8'hD9, 8'h56);
      rd_sfr(8'hDA, 8'h34);
      rd_sfr(8'hDB, 8'h12);
      // a slow report while ready is still set must be dropped
      fire(1'b0, 4'h5, {2'b00, 24'h654321});
      rd_sfr(8'hD9, 8'h56);
      wr_bit(8'hDF, 1'b0);
      rd_bit(8'hDF, 1'b0);
      fire(1'b0, 4'h1, {2'b10, 24'hAABBCC});
      rd_sfr(8'hD8, 8'h88);
      wr_sfr(8'hD1, 8'h22);
      rd_sfr(8'hD8, 8'h80);
      // zero-scale calibration, then a failing full-scale one
      wr_sfr(8'hD1, 8'h26);
      rd_bit(8'hDF, 1'b0);
      fire(1'b0, 4'h2, {2'b00, 24'h111111});
      rd_sfr(8'hD8, 8'hA0);
      check(priOffset, 24'h111111);
      wr_sfr(8'hD1, 8'h27);
      rd_sfr(8'hD8, 8'h00);
      fire(1'b0, 4'h0, {2'b01, 24'h222222});
      rd_sfr(8'hD8, 8'hA8);
      check(priGain, 24'h400000);
      // reference watch counts only while a converter runs
      refBad = 1'b1;
      wr_sfr(8'hD1, 8'h08);
      rd_bit(8'hDC, 1'b0);
      wr_sfr(8'hD1, 8'h22);
      rd_bit(8'hDC, 1'b1);
      wr_bit(8'hDF, 1'b0);
      fire(1'b0, 4'h0, {2'b00, 24'h000123});
      rd_sfr(8'hDB, 8'hFF);
      rd_sfr(8'hD8, 8'h98);
      refBad = 1'b0;
      rd_bit(8'hDC, 1'b0);
      wr_bit(8'hD8, 1'b1);
      rd_bit(8'hD8, 1'b0);
      // auxiliary side, then a calibration that can never finish
      wr_sfr(8'hD8, 8'h00);
      wr_sfr(8'hD1, 8'h12);
      check(24'(auxRun), 24'h1);
      fire(1'b1, 4'h3, {2'b10, 24'hBEEF00});
      rd_sfr(8'hDC, 8'hEF);
      rd_sfr(8'hDD, 8'hBE);
      rd_sfr(8'hD8, 8'h44);
      wr_sfr(8'hD8, 8'h00);
      auxTempSel = 1'b1;
      wr_sfr(8'hD1, 8'h16);
      fire(1'b1, 4'h0, {2'b00, 24'h777700});
      rd_sfr(8'hD8, 8'h00);
      check(24'(auxOffset), 24'h8000);
      // mid-run reset brings back power-on values everywhere
      reset_n = 1'b0;
      @(posedge core_clk) #1;
      check(24'(modeCtrl), 24'h08);
      check(priOffset, 24'h800000);
      check(24'(auxGain), 24'h4000);
      check(24'(decimation), 24'h45);
      check(24'(sfrRdData), 24'h00);
      reset_n = 1'b1;
      // a write while the clock enable is low must be lost
      clkEn = 1'b0;
      wr_sfr(8'hD4, 8'h77);
      clkEn = 1'b1;
      rd_sfr(8'hD4, 8'h45);
      rd_sfr(8'hD8, 8'h00);
      end_of_test();
   end
endmodule : tb_top
